// ---- hw/tlx_pkg.sv ----
package tlx_pkg;

    // Instruction word fields, bit 31 of the word is field bit 0
    localparam int          TLX_OPC_HI       = 31;
    localparam int          TLX_OPC_LO       = 26;
    localparam int          TLX_F6_HI        = 25;
    localparam int          TLX_F6_LO        = 21;
    localparam int          TLX_F11_HI       = 20;
    localparam int          TLX_F11_LO       = 16;
    localparam int          TLX_F16_HI       = 15;
    localparam int          TLX_F16_LO       = 11;
    localparam int          TLX_XO_HI        = 10;
    localparam int          TLX_XO_LO        = 1;
    localparam int          TLX_RC_BIT       = 0;
    localparam int          TLX_IMM_W        = 16;

    // Opcodes
    localparam logic [5:0]  TLX_OPC_EXT      = 6'h1f;
    localparam logic [5:0]  TLX_OPC_TRAP_IMM = 6'h03;
    localparam logic [9:0]  TLX_XO_LOAD_ITLB = 10'h3f2;
    localparam logic [9:0]  TLX_XO_SYNC      = 10'h236;
    localparam logic [9:0]  TLX_XO_TRAP_REG  = 10'h004;
    localparam logic [9:0]  TLX_XO_XOR       = 10'h13c;

    // Condition mask positions (mask field MSB is mask bit 0)
    localparam int          TLX_TO_LT        = 4;
    localparam int          TLX_TO_GT        = 3;
    localparam int          TLX_TO_EQ        = 2;
    localparam int          TLX_TO_LTU       = 1;
    localparam int          TLX_TO_GTU       = 0;

    // Translation entry geometry
    localparam int          TLX_ITLB_IDX_W   = 5;
    localparam int          TLX_PAGE_BITS    = 12;
    localparam int          TLX_OUTST_W      = 4;

    // APB register byte offsets
    localparam logic [7:0]  TLX_REG_STATUS   = 8'h00;
    localparam logic [7:0]  TLX_REG_MASK     = 8'h04;
    localparam logic [7:0]  TLX_REG_MISS_ADR = 8'h08;
    localparam logic [7:0]  TLX_REG_MISS_CMP = 8'h0c;
    localparam logic [7:0]  TLX_REG_REAL_PG  = 8'h10;
    localparam logic [7:0]  TLX_REG_SYNC     = 8'h14;

    // Status and mask bit positions
    localparam int          TLX_EV_TRAP      = 0;
    localparam int          TLX_EV_PRIV      = 1;
    localparam int          TLX_EV_ILLEGAL   = 2;
    localparam int          TLX_EV_MISS      = 3;
    localparam int          TLX_EV_SYNC      = 4;
    localparam int          TLX_EV_W         = 5;
    localparam logic [4:0]  TLX_MASK_RST     = 5'h00;

    typedef enum logic [0:0] {
        TLX_EX_IDLE,
        TLX_EX_SYNC
    } tlx_exec_state_t;

    typedef struct packed {
        logic                      we;
        logic [TLX_ITLB_IDX_W-1:0] idx;
        logic [31:0]               hi;
        logic [31:0]               lo;
    } tlx_tlb_wr_t;

    typedef struct packed {
        logic        we;
        logic [4:0]  idx;
        logic [31:0] data;
    } tlx_gpr_wr_t;

    // Condition field 0: less, greater, zero, summary overflow
    typedef struct packed {
        logic we;
        logic less_flag;
        logic greater_flag;
        logic zero_flag;
        logic so;
    } tlx_cr0_t;

    typedef struct packed {
        tlx_exec_state_t        mode;
        logic [TLX_OUTST_W-1:0] outstanding;
        logic                   ack_s1;
        logic                   ack_s2;
        logic                   ack_s3;
        logic [31:0]            instr_miss_address;
        logic [31:0]            instr_miss_compare;
        logic [31:0]            real_page_address;
        logic [TLX_EV_W-1:0]    status;
        logic [TLX_EV_W-1:0]    mask;
        logic [31:0]            prdata;
        logic                   pslverr;
        tlx_tlb_wr_t            tlb_wr;
        tlx_gpr_wr_t            gpr_wr;
        tlx_cr0_t               cr0;
        logic                   trap;
        logic                   priv_exc;
        logic                   illegal;
        logic                   sync_done;
    } tlx_state_t;

endpackage

// ---- hw/tlx_execute.sv ----
// Behaviour
// - Instruction translation load picks its entry from the second operand register value.
// - Translation load writes miss-compare register into the entry upper word.
// - Translation load writes real page merged with miss address into lower word.
// - Instruction miss captures effective address and first page-table word.
// - Translation load leaves exception register alone; record bit set is invalid.
// - Translation load is privileged and refused in user state.
// - Translation sync waits until all earlier invalidates completed on other processors, while no more than 15 are in flight.
// - Translation sync is privileged, leaves exception register, record bit invalid.
// - Register trap compares operands, masks outcomes, traps when result nonzero.
// - Mask bits select signed lt, gt, equal, unsigned lt, unsigned gt.
// - Immediate trap compares with sign-extended 16-bit immediate, same masked decision.
// - Trap operations never touch exception register or condition field 0.
// - Register XOR writes source XOR second operand into target register.
// - XOR never alters exception register; record bit updates field 0 flags.
`timescale 1ns/1ps
`default_nettype none

module tlx_execute
    import tlx_pkg::*;
(
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 issue_valid,
    input  wire logic [31:0]          issue_instr,
    output logic                      issue_ready,
    input  wire logic                 priv_mode,
    input  wire logic                 xer_so,
    output logic      [4:0]           src_sel,
    output logic      [4:0]           first_sel,
    output logic      [4:0]           second_sel,
    input  wire logic [31:0]          src_val,
    input  wire logic [31:0]          first_val,
    input  wire logic [31:0]          second_val,
    input  wire logic                 instr_miss_address_valid,
    input  wire logic [31:0]          instr_miss_address_ea,
    input  wire logic [31:0]          instr_miss_address_pte_word,
    input  wire logic                 inval_issued,
    input  wire logic                 remote_inval_ack,
    output logic                      sync_req,
    output tlx_tlb_wr_t               tlb_wr,
    output tlx_gpr_wr_t               gpr_wr,
    output tlx_cr0_t                  cr0,
    output logic                      trap,
    output logic                      priv_exc,
    output logic                      illegal,
    output logic                      sync_done,
    output logic                      irq
);

    tlx_state_t st;
    tlx_state_t next_st;

    // Instruction fields
    logic [5:0]  opc;
    logic [9:0]  xo;
    logic        rc;
    logic [4:0]  to_mask;
    logic [31:0] simm;
    logic        fire;
    logic        is_ext;
    logic        is_load;
    logic        is_sync;
    logic        is_trap_reg;
    logic        is_trap_imm;
    logic        is_xor;

    assign opc         = issue_instr[TLX_OPC_HI:TLX_OPC_LO];
    assign xo          = issue_instr[TLX_XO_HI:TLX_XO_LO];
    assign rc          = issue_instr[TLX_RC_BIT];
    assign to_mask     = issue_instr[TLX_F6_HI:TLX_F6_LO];
    assign simm        = {{(32-TLX_IMM_W){issue_instr[TLX_IMM_W-1]}}, issue_instr[TLX_IMM_W-1:0]};
    assign src_sel     = issue_instr[TLX_F6_HI:TLX_F6_LO];
    assign first_sel   = issue_instr[TLX_F11_HI:TLX_F11_LO];
    assign second_sel  = issue_instr[TLX_F16_HI:TLX_F16_LO];
    assign issue_ready = (st.mode == TLX_EX_IDLE);
    assign fire        = issue_valid && issue_ready;
    assign is_ext      = (opc == TLX_OPC_EXT);
    assign is_load     = is_ext && (xo == TLX_XO_LOAD_ITLB);
    assign is_sync     = is_ext && (xo == TLX_XO_SYNC);
    assign is_trap_reg = is_ext && (xo == TLX_XO_TRAP_REG);
    assign is_trap_imm = (opc == TLX_OPC_TRAP_IMM);
    assign is_xor      = is_ext && (xo == TLX_XO_XOR);

    // Outcome vector laid out to match the mask field
    function automatic logic [4:0] tlx_compare(input logic [31:0] a, input logic [31:0] b);
        logic [4:0] r;
        r             = 5'h00;
        r[TLX_TO_LT]  = $signed(a) < $signed(b);
        r[TLX_TO_GT]  = $signed(a) > $signed(b);
        r[TLX_TO_EQ]  = (a == b);
        r[TLX_TO_LTU] = a < b;
        r[TLX_TO_GTU] = a > b;
        return r;
    endfunction

    logic [31:0] xor_res;
    logic        ack_evt;
    logic        apb_wr;
    logic        apb_setup;
    logic [4:0]  w1c;
    logic [4:0]  events;

    assign xor_res   = src_val ^ second_val;
    assign ack_evt   = st.ack_s2 ^ st.ack_s3;
    assign apb_wr    = psel && penable && pwrite;
    assign apb_setup = psel && !penable;

    // Next-state logic for the whole block
    always_comb begin
        next_st = st;
        next_st.tlb_wr.we = 1'b0;
        next_st.gpr_wr.we = 1'b0;
        next_st.cr0.we    = 1'b0;
        next_st.trap      = 1'b0;
        next_st.priv_exc  = 1'b0;
        next_st.illegal   = 1'b0;
        next_st.sync_done = 1'b0;
        w1c               = 5'h00;

        // Remote ack toggles once per completed invalidate; a difference between the second and third stages marks one
        next_st.ack_s1 = remote_inval_ack;
        next_st.ack_s2 = st.ack_s1;
        next_st.ack_s3 = st.ack_s2;

        // Invalidates still in flight on other processors, saturating both ways
        if (inval_issued && !ack_evt) begin
            if (st.outstanding != '1) begin
                next_st.outstanding = st.outstanding + 1'b1;
            end
        end else if (!inval_issued && ack_evt) begin
            if (st.outstanding != '0) begin
                next_st.outstanding = st.outstanding - 1'b1;
            end
        end

        // Execute; privilege check before anything else takes effect
        if (fire) begin
            if ((is_load || is_sync) && !priv_mode) begin
                next_st.priv_exc = 1'b1;
            end else if ((is_load || is_sync) && rc) begin
                next_st.illegal = 1'b1;
            end else if (is_load) begin
                // Exception register untouched: no path to it exists here
                next_st.tlb_wr.we  = 1'b1;
                next_st.tlb_wr.idx = second_val[TLX_ITLB_IDX_W-1:0];
                next_st.tlb_wr.hi  = st.instr_miss_compare;
                next_st.tlb_wr.lo  = {st.real_page_address[31:TLX_PAGE_BITS],
                                      st.instr_miss_address[TLX_PAGE_BITS-1:0]};
            end else if (is_sync) begin
                next_st.mode = TLX_EX_SYNC;
            end else if (is_trap_reg) begin
                // No register or condition write on either trap path
                next_st.trap = |(to_mask & tlx_compare(first_val, second_val));
            end else if (is_trap_imm) begin
                next_st.trap = |(to_mask & tlx_compare(first_val, simm));
            end else if (is_xor) begin
                next_st.gpr_wr.we   = 1'b1;
                next_st.gpr_wr.idx  = first_sel;
                next_st.gpr_wr.data = xor_res;
                if (rc) begin
                    next_st.cr0.we           = 1'b1;
                    next_st.cr0.less_flag    = xor_res[31];
                    next_st.cr0.greater_flag = !xor_res[31] && (xor_res != '0);
                    next_st.cr0.zero_flag    = (xor_res == '0);
                    next_st.cr0.so           = xer_so;
                end
            end
        end

        // Sync holds the issue port until nothing is left in flight
        if (st.mode == TLX_EX_SYNC && st.outstanding == '0) begin
            next_st.mode      = TLX_EX_IDLE;
            next_st.sync_done = 1'b1;
        end

        // Software writes; a miss capture in the same cycle wins
        if (apb_wr) begin
            unique case (paddr)
                TLX_REG_STATUS:   w1c = pwdata[TLX_EV_W-1:0];
                TLX_REG_MASK:     next_st.mask = pwdata[TLX_EV_W-1:0];
                TLX_REG_MISS_ADR: next_st.instr_miss_address = pwdata;
                TLX_REG_MISS_CMP: next_st.instr_miss_compare = pwdata;
                TLX_REG_REAL_PG:  next_st.real_page_address = pwdata;
                default:          ;
            endcase
        end
        if (instr_miss_address_valid) begin
            next_st.instr_miss_address = instr_miss_address_ea;
            next_st.instr_miss_compare = instr_miss_address_pte_word;
        end

        // Sticky events; a new event beats a clear in the same cycle
        events                  = 5'h00;
        events[TLX_EV_TRAP]     = next_st.trap;
        events[TLX_EV_PRIV]     = next_st.priv_exc;
        events[TLX_EV_ILLEGAL]  = next_st.illegal;
        events[TLX_EV_MISS]     = instr_miss_address_valid;
        events[TLX_EV_SYNC]     = next_st.sync_done;
        next_st.status          = (st.status & ~w1c) | events;

        // Read data latched in setup so the access phase needs no wait state
        if (apb_setup) begin
            next_st.pslverr = 1'b0;
            unique case (paddr)
                TLX_REG_STATUS:   next_st.prdata = {27'h0, st.status};
                TLX_REG_MASK:     next_st.prdata = {27'h0, st.mask};
                TLX_REG_MISS_ADR: next_st.prdata = st.instr_miss_address;
                TLX_REG_MISS_CMP: next_st.prdata = st.instr_miss_compare;
                TLX_REG_REAL_PG:  next_st.prdata = st.real_page_address;
                TLX_REG_SYNC:     next_st.prdata = {26'h0, st.mode == TLX_EX_SYNC, 1'b0, st.outstanding};
                default: begin
                    next_st.prdata  = 32'h0;
                    next_st.pslverr = 1'b1;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st      <= '0;
            st.mode <= TLX_EX_IDLE;
            st.mask <= TLX_MASK_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    assign prdata    = st.prdata;
    assign pready    = 1'b1;
    assign pslverr   = st.pslverr && psel && penable;
    assign sync_req  = (st.mode == TLX_EX_SYNC);
    assign tlb_wr    = st.tlb_wr;
    assign gpr_wr    = st.gpr_wr;
    assign cr0       = st.cr0;
    assign trap      = st.trap;
    assign priv_exc  = st.priv_exc;
    assign illegal   = st.illegal;
    assign sync_done = st.sync_done;
    assign irq       = |(st.status & st.mask);

    default clocking tlx_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_load_index;
        fire && is_load && priv_mode && !rc |=> tlb_wr.we && tlb_wr.idx == $past(second_val[TLX_ITLB_IDX_W-1:0]);
    endproperty
    a_load_index: assert property (p_load_index) else $error("entry index wrong");

    property p_load_upper;
        fire && is_load && priv_mode && !rc |=> tlb_wr.hi == $past(st.instr_miss_compare);
    endproperty
    a_load_upper: assert property (p_load_upper) else $error("upper word wrong");

    property p_load_lower;
        tlb_wr.we |-> tlb_wr.lo == {$past(st.real_page_address[31:TLX_PAGE_BITS]),
                                    $past(st.instr_miss_address[TLX_PAGE_BITS-1:0])};
    endproperty
    a_load_lower: assert property (p_load_lower) else $error("lower word wrong");

    property p_miss_capture;
        instr_miss_address_valid |=> st.instr_miss_address == $past(instr_miss_address_ea) && st.instr_miss_compare == $past(instr_miss_address_pte_word);
    endproperty
    a_miss_capture: assert property (p_miss_capture) else $error("miss not captured");

    property p_bad_form;
        fire && (is_load || is_sync) && priv_mode && rc |=> illegal && !tlb_wr.we ##1 issue_ready;
    endproperty
    a_bad_form: assert property (p_bad_form) else $error("invalid form accepted");

    property p_user_refused;
        fire && (is_load || is_sync) && !priv_mode |=> priv_exc && !tlb_wr.we && issue_ready;
    endproperty
    a_user_refused: assert property (p_user_refused) else $error("privileged op ran in user state");

    property p_user_quiet;
        fire && (is_load || is_sync) && !priv_mode |=> !gpr_wr.we && !cr0.we && !trap && !sync_req;
    endproperty
    a_user_quiet: assert property (p_user_quiet) else $error("refused op left effects");

    property p_sync_wait;
        sync_req && st.outstanding != '0 |=> !sync_done && !issue_ready;
    endproperty
    a_sync_wait: assert property (p_sync_wait) else $error("sync finished early");

    property p_sync_release;
        sync_req && st.outstanding == '0 |=> sync_done && !sync_req && issue_ready;
    endproperty
    a_sync_release: assert property (p_sync_release) else $error("sync did not finish");

    property p_sync_priv;
        fire && is_sync && priv_mode && !rc |=> sync_req [*1] ##0 !gpr_wr.we && !cr0.we;
    endproperty
    a_sync_priv: assert property (p_sync_priv) else $error("sync not entered");

    property p_trap_eq;
        fire && is_trap_reg && to_mask == 5'h04 && first_val == second_val |=> trap;
    endproperty
    a_trap_eq: assert property (p_trap_eq) else $error("equal trap missed");

    property p_trap_ltu;
        fire && is_trap_reg && to_mask == 5'h02 && first_val >= second_val |=> !trap;
    endproperty
    a_trap_ltu: assert property (p_trap_ltu) else $error("unsigned mask bit misread");

    property p_trap_imm;
        fire && is_trap_imm && to_mask == 5'h10 && $signed(first_val) < $signed(simm) |=> trap;
    endproperty
    a_trap_imm: assert property (p_trap_imm) else $error("immediate trap missed");

    property p_trap_quiet;
        fire && (is_trap_reg || is_trap_imm) |=> !cr0.we && !gpr_wr.we;
    endproperty
    a_trap_quiet: assert property (p_trap_quiet) else $error("trap wrote state");

    property p_xor_data;
        fire && is_xor |=> gpr_wr.we && gpr_wr.data == ($past(src_val) ^ $past(second_val));
    endproperty
    a_xor_data: assert property (p_xor_data) else $error("xor result wrong");

    property p_xor_record;
        fire && is_xor |=> cr0.we == $past(rc);
    endproperty
    a_xor_record: assert property (p_xor_record) else $error("field 0 update wrong");

    property p_xor_flags;
        cr0.we |-> $onehot({cr0.less_flag, cr0.greater_flag, cr0.zero_flag}) && cr0.so == $past(xer_so);
    endproperty
    a_xor_flags: assert property (p_xor_flags) else $error("flags not one-hot");

endmodule

`default_nettype wire

// ---- test/tlx_far_side.sv ----
`timescale 1ns/1ps
`default_nettype none

// Register file and remote processors beside the execute block
module tlx_far_side
    import tlx_pkg::*;
#(
    parameter int ACK_DELAY = 6
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [4:0]  src_sel,
    input  wire logic [4:0]  first_sel,
    input  wire logic [4:0]  second_sel,
    input  wire tlx_gpr_wr_t gpr_wr,
    input  wire logic        inval_issued,
    output logic      [31:0] src_val,
    output logic      [31:0] first_val,
    output logic      [31:0] second_val,
    output logic             remote_inval_ack
);
    logic [31:0] regs [32];
    int          pending;
    int          timer;

    // Read ports answer in the same cycle as the selects
    assign src_val    = regs[src_sel];
    assign first_val  = regs[first_sel];
    assign second_val = regs[second_sel];

    // Each invalidate completes remotely after a slow fixed delay
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending          <= 0;
            timer            <= 0;
            remote_inval_ack <= 1'b0;
        end else begin
            if (gpr_wr.we) begin
                regs[gpr_wr.idx] <= gpr_wr.data; // Late update so a same-edge read sees the old value
            end
            // Timer only runs while something is pending, so no toggle when idle
            if (timer == ACK_DELAY) begin
                timer            <= 0;
                pending          <= pending + int'(inval_issued) - 1;
                remote_inval_ack <= ~remote_inval_ack;
            end else begin
                timer   <= (pending == 0) ? 0 : timer + 1;
                pending <= pending + int'(inval_issued);
            end
        end
    end
endmodule

`default_nettype wire

// ---- test/tlx_execute_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tlx_execute_tb_top
    import tlx_pkg::*;
;
    typedef struct {
        logic [31:0] i;
        logic [1:0]  p;
        logic [31:0] a, b, s, d;
        logic [5:0]  e;
        logic [3:0]  f;
    } tlx_row_t;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic        issue_valid, issue_ready, priv_mode, xer_so, instr_miss_address_valid, inval_issued;
    logic        remote_inval_ack, sync_req, trap, priv_exc, illegal, sync_done, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, issue_instr, src_val, first_val, second_val, instr_miss_address_ea, instr_miss_address_pte_word, rd;
    logic [4:0]  src_sel, first_sel, second_sel;
    tlx_tlb_wr_t tlb_wr;
    tlx_gpr_wr_t gpr_wr;
    tlx_cr0_t    cr0;
    int          n_errors, n_tests, k;

    localparam logic [31:0] ta = 32'h90003000;
    localparam logic [31:0] tb = 32'h789a789b;
    localparam logic [31:0] lo = 32'h00123234;

    // Extended-opcode word with fixed operand registers 5 and 7
    function automatic logic [31:0] ext(input logic [4:0] t, input logic [9:0] x, input logic c);
        return {TLX_OPC_EXT, t, 5'h05, 5'h07, x, c};
    endfunction

    // Fields: word, {so,priv}, first, second, source, data, events, flags
    tlx_row_t rows [19] = '{
        '{ext(5'h04,TLX_XO_XOR,1'b0),2'h2,32'h0,tb,ta,32'he89a489b,6'h10,4'h0},
        '{ext(5'h04,TLX_XO_XOR,1'b1),2'h3,32'h0,tb,32'hb0043000,32'hc89e489b,6'h18,4'h9},
        '{ext(5'h04,TLX_XO_XOR,1'b1),2'h1,32'h0,tb,tb,32'h0,6'h18,4'h2},
        '{ext(5'h04,TLX_XO_XOR,1'b1),2'h1,32'h0,32'h0,32'h1,32'h1,6'h18,4'h4},
        '{ext(5'h10,TLX_XO_TRAP_REG,1'b0),2'h1,ta,tb,32'h0,32'h0,6'h04,4'h0},
        '{ext(5'h08,TLX_XO_TRAP_REG,1'b0),2'h1,ta,tb,32'h0,32'h0,6'h00,4'h0},
        '{ext(5'h02,TLX_XO_TRAP_REG,1'b0),2'h1,ta,tb,32'h0,32'h0,6'h00,4'h0},
        '{ext(5'h01,TLX_XO_TRAP_REG,1'b0),2'h1,ta,tb,32'h0,32'h0,6'h04,4'h0},
        '{ext(5'h04,TLX_XO_TRAP_REG,1'b0),2'h1,tb,tb,32'h0,32'h0,6'h04,4'h0},
        '{ext(5'h1b,TLX_XO_TRAP_REG,1'b0),2'h1,tb,tb,32'h0,32'h0,6'h00,4'h0},
        '{{TLX_OPC_TRAP_IMM,5'h04,5'h05,16'h0010},2'h1,32'h10,32'h0,32'h0,32'h0,6'h04,4'h0},
        '{{TLX_OPC_TRAP_IMM,5'h10,5'h05,16'hfff0},2'h1,32'hffffffef,32'h0,32'h0,32'h0,6'h04,4'h0},
        '{{TLX_OPC_TRAP_IMM,5'h01,5'h05,16'hfff0},2'h1,32'hffffffef,32'h0,32'h0,32'h0,6'h00,4'h0},
        '{ext(5'h00,TLX_XO_LOAD_ITLB,1'b0),2'h1,32'h0,32'h23,32'h0,lo,6'h20,4'h0},
        '{ext(5'h00,TLX_XO_LOAD_ITLB,1'b0),2'h0,32'h0,32'h23,32'h0,lo,6'h02,4'h0},
        '{ext(5'h00,TLX_XO_LOAD_ITLB,1'b1),2'h1,32'h0,32'h23,32'h0,lo,6'h01,4'h0},
        '{ext(5'h00,TLX_XO_SYNC,1'b0),2'h0,32'h0,32'h0,32'h0,32'h0,6'h02,4'h0},
        '{ext(5'h00,TLX_XO_SYNC,1'b1),2'h1,32'h0,32'h0,32'h0,32'h0,6'h01,4'h0},
        '{32'h68a71234,2'h1,32'h0,32'h0,32'h0,32'h0,6'h00,4'h0}
    };

    tlx_execute tlx_execute_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .issue_valid, .issue_instr, .issue_ready, .priv_mode, .xer_so, .src_sel,
        .first_sel, .second_sel, .src_val, .first_val, .second_val, .instr_miss_address_valid, .instr_miss_address_ea,
        .instr_miss_address_pte_word, .inval_issued, .remote_inval_ack, .sync_req, .tlb_wr, .gpr_wr, .cr0, .trap,
        .priv_exc, .illegal, .sync_done, .irq);

    tlx_far_side tlx_far_side_inst (.pclk, .presetn, .src_sel, .first_sel, .second_sel, .gpr_wr,
        .inval_issued, .src_val, .first_val, .second_val, .remote_inval_ack);

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; waits for pready, never assumes a latency
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        #1;
    endtask

    // Offer one word at a clock edge; returns just after the taking edge has landed
    task automatic issue(input logic [31:0] w, input logic [1:0] p);
        @(posedge pclk);
        issue_instr <= w;
        {xer_so, priv_mode} <= p;
        issue_valid <= 1'b1;
        do @(posedge pclk); while (issue_ready !== 1'b1);
        issue_valid <= 1'b0;
        #1;
    endtask

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        n_errors++;
        conclude();
    end

    initial begin
        {presetn, psel, penable, pwrite, issue_valid, priv_mode, xer_so, instr_miss_address_valid, inval_issued} = '0;
        {paddr, pwdata, issue_instr, instr_miss_address_ea, instr_miss_address_pte_word} = '0;
        n_errors = 0;
        n_tests = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // Miss capture and real page feed the translation load rows
        @(posedge pclk);
        {instr_miss_address_valid, instr_miss_address_ea, instr_miss_address_pte_word} <= {1'b1, 32'ha5a51234, 32'h800000ff};
        @(posedge pclk);
        instr_miss_address_valid <= 1'b0;
        apb(1'b1, TLX_REG_REAL_PG, 32'h00123fff);
        foreach (rows[j]) begin
            // Let the previous row's register write land before loading operands
            @(posedge pclk);
            #1;
            tlx_far_side_inst.regs[5] = rows[j].a;
            tlx_far_side_inst.regs[7] = rows[j].b;
            tlx_far_side_inst.regs[4] = rows[j].s;
            issue(rows[j].i, rows[j].p);
            chk({tlb_wr.we, gpr_wr.we, cr0.we, trap, priv_exc, illegal}, rows[j].e);
            if (rows[j].e[4]) chk({gpr_wr.idx, gpr_wr.data}, {5'h05, rows[j].d});
            if (rows[j].e[3]) chk(cr0[3:0], rows[j].f);
            if (rows[j].e[5]) chk({tlb_wr.idx, tlb_wr.hi, tlb_wr.lo}, {rows[j].b[4:0], 32'h800000ff, lo});
        end
        // Sticky events, mask and write-one-to-clear
        apb(1'b0, TLX_REG_STATUS, 32'h0);
        chk(rd, 32'h0f);
        apb(1'b1, TLX_REG_MASK, 32'h1);
        chk(irq, 1'b1);
        apb(1'b1, TLX_REG_STATUS, 32'h1);
        chk(irq, 1'b0);
        apb(1'b0, TLX_REG_STATUS, 32'h0);
        chk(rd, 32'h0e);
        apb(1'b0, TLX_REG_MISS_ADR, 32'h0);
        chk(rd, 32'ha5a51234);
        apb(1'b0, TLX_REG_MISS_CMP, 32'h0);
        chk(rd, 32'h800000ff);
        apb(1'b0, 8'h40, 32'h0);
        chk({er, rd}, {1'b1, 32'h0});
        // Two invalidates still in flight when the sync arrives
        @(posedge pclk);
        inval_issued <= 1'b1;
        repeat (2) @(posedge pclk);
        inval_issued <= 1'b0;
        issue(ext(5'h00, TLX_XO_SYNC, 1'b0), 2'h1);
        chk({sync_req, issue_ready, sync_done}, 3'b100);
        apb(1'b0, TLX_REG_SYNC, 32'h0);
        chk(rd, 32'h22);
        for (k = 0; k < 200 && sync_done !== 1'b1; k++) begin
            @(posedge pclk);
            #1;
        end
        chk({k > 6, tlx_far_side_inst.pending}, {1'b1, 32'h0});
        chk({sync_req, issue_ready}, 2'b01);
        apb(1'b0, TLX_REG_STATUS, 32'h0);
        chk(rd, 32'h1e);
        // Reset in mid-run clears events and mask
        @(posedge pclk);
        presetn <= 1'b0;
        #1;
        chk({irq, issue_ready, pready, sync_req, trap, gpr_wr.we}, 6'b011000);
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, TLX_REG_STATUS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, TLX_REG_MASK, 32'h0);
        chk(rd, 32'h0);
        conclude();
    end
endmodule

`default_nettype wire
